// *** rtl/exec_pkg.sv ***
// constants, opcodes and states shared by the execution unit and its stack
// assumes instruction decode has already mapped opcode bits onto op_t
package exec_pkg;
  localparam int         DATA_WIDTH       = 8;
  localparam int         PC_WIDTH         = 11;
  localparam int         JUMP_FIELD_WIDTH = 10;
  localparam int         REG_ADDR_WIDTH   = 6;
  localparam int         BIT_INDEX_WIDTH  = 3;
  localparam int         UPPER_PC_BIT     = 2;
  localparam int         NIBBLE_WIDTH     = 4;
  localparam int         STACK_DEPTH      = 5;
  localparam logic [10:0] RESET_PC        = 11'h000;
  localparam logic [10:0] SWI_VECTOR      = 11'h002;
  localparam logic [10:0] PC_STEP         = 11'h001;
  localparam logic [10:0] PC_SKIP_STEP    = 11'h002;
  localparam logic [7:0]  RESET_DATA      = 8'h00;
  localparam logic [7:0]  BIT_ONE         = 8'h01;
  localparam int         CYCLES_BRANCH    = 2;
  localparam int         CYCLES_SKIP      = 2;
  localparam int         CYCLES_SWI_LONG  = 3;
  localparam int         CYCLES_SWI_SHORT = 2;

  typedef enum logic [4:0] {
    no_op,
    rotate_right_carry_op,
    nibble_exchange_op,
    load_immediate_acc_op,
    add_immediate_op,
    subtract_immediate_op,
    and_immediate_op,
    or_immediate_op,
    xor_immediate_op,
    return_with_literal_op,
    call_op,
    jump_op,
    add_with_carry_reg_op,
    add_register_op,
    skip_op,
    soft_interrupt_op,
    bit_clear_op,
    bit_set_op
  } op_t;

  typedef enum logic [1:0] {
    st_run,
    st_wait_first,
    st_wait_last
  } state_t;
endpackage

// *** rtl/stack_if.sv ***
// push/pop carrier between the execution unit and the return stack
// assumes one push or one pop per clock, never both
`timescale 1ns/100ps
`default_nettype none
interface stack_if;
  logic        push;
  logic        pop;
  logic [10:0] push_data;
  logic [10:0] top;
  modport user  (output push, output pop, output push_data, input top);
  modport store (input push, input pop, input push_data, output top);
endinterface
`default_nettype wire

// *** rtl/return_stack.sv ***
// five entry hardware return stack, shifting, top held in a register
// assumes the core never pushes and pops in one cycle; overflow drops the oldest
`timescale 1ns/100ps
`default_nettype none
module return_stack
  import exec_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // stack port
  stack_if.store    stk
);
  logic [PC_WIDTH-1:0] entry      [STACK_DEPTH];
  logic [PC_WIDTH-1:0] next_entry [STACK_DEPTH];

  genvar g;
  generate
    for (g = 0; g < STACK_DEPTH; g++) begin : g_entry
      always_comb begin
        next_entry[g] = entry[g];
        if (stk.push) begin
          next_entry[g] = (g == 0) ? stk.push_data : entry[(g == 0) ? 0 : g - 1];
        end else if (stk.pop) begin
          next_entry[g] = entry[(g == STACK_DEPTH - 1) ? g : g + 1];
        end
      end
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          entry[g] <= RESET_PC;
        end else begin
          entry[g] <= next_entry[g];
        end
      end
    end
  endgenerate

  assign stk.top = entry[0];
endmodule
`default_nettype wire

// *** rtl/immediate_branch_alu_exec.sv ***
// execution unit: immediate and register arithmetic, rotate, swap, bit ops,
// branches, skips and software interrupt with cycle accounting
// assumes register read data and opcode fields arrive on this clock, aligned
// with i_instr_valid; the fetch path holds while o_busy is high
`timescale 1ns/100ps
`default_nettype none
module immediate_branch_alu_exec
  import exec_pkg::*;
#(
  parameter bit LONG_SWI = 1'b1
) (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_reset_n,
  // decoded instruction
  input  wire logic                       i_instr_valid,
  input  wire exec_pkg::op_t              i_opcode,
  input  wire logic [7:0]                 i_imm,
  input  wire logic [9:0]                 i_jump_addr,
  input  wire logic [5:0]                 i_reg_addr,
  input  wire logic [2:0]                 i_bit_index,
  input  wire logic                       i_dest_sel,
  input  wire logic                       i_skip_cond,
  // operands from surrounding core
  input  wire logic [7:0]                 i_reg_rdata,
  input  wire logic [7:0]                 i_upper_buffer,
  // sequencing
  output logic                            o_busy,
  output logic [10:0]                     o_pc,
  // accumulator and status
  output logic [7:0]                      o_acc,
  output logic                            o_carry,
  output logic                            o_digit_carry,
  output logic                            o_zero,
  // register file write
  output logic                            o_reg_we,
  output logic [5:0]                      o_reg_addr,
  output logic [7:0]                      o_reg_wdata
);
  localparam int SWI_CYCLES = LONG_SWI ? CYCLES_SWI_LONG : CYCLES_SWI_SHORT;

  state_t              state;
  state_t              next_state;
  logic                busy;
  logic                next_busy;
  logic [PC_WIDTH-1:0] pc;
  logic [PC_WIDTH-1:0] next_pc;
  logic [7:0]          acc;
  logic [7:0]          next_acc;
  logic                carry;
  logic                next_carry;
  logic                digit_carry;
  logic                next_digit_carry;
  logic                zero;
  logic                next_zero;
  logic                reg_we;
  logic                next_reg_we;
  logic [5:0]          reg_addr;
  logic [5:0]          next_reg_addr;
  logic [7:0]          reg_wdata;
  logic [7:0]          next_reg_wdata;

  // shared adder
  logic [7:0]          add_a;
  logic [7:0]          add_b;
  logic                add_cin;
  logic [8:0]          add_sum;
  logic [4:0]          add_low;
  logic [7:0]          result;
  logic [7:0]          bit_mask;
  logic                take;

  stack_if stk ();

  return_stack u_stack (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .stk       (stk)
  );

  assign take = i_instr_valid && (state == st_run);

  always_comb begin
    add_a   = acc;
    add_b   = i_reg_rdata;
    add_cin = 1'b0;
    case (i_opcode)
      add_immediate_op: begin
        add_b = i_imm;
      end
      subtract_immediate_op: begin
        // immediate plus inverted accumulator plus one
        add_a   = i_imm;
        add_b   = ~acc;
        add_cin = 1'b1;
      end
      add_with_carry_reg_op: begin
        add_cin = carry;
      end
      default: begin
        add_b = i_reg_rdata;
      end
    endcase
    add_sum  = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
    add_low  = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
    bit_mask = BIT_ONE << i_bit_index;
  end

  always_comb begin
    next_state       = st_run;
    next_pc          = pc;
    next_acc         = acc;
    next_carry       = carry;
    next_digit_carry = digit_carry;
    next_zero        = zero;
    next_reg_we      = 1'b0;
    next_reg_addr    = reg_addr;
    next_reg_wdata   = reg_wdata;
    result           = RESET_DATA;
    stk.push         = 1'b0;
    stk.pop          = 1'b0;
    stk.push_data    = 11'(pc + PC_STEP);
    case (state)
      st_wait_first: begin
        next_state = st_wait_last;
      end
      st_wait_last: begin
        next_state = st_run;
      end
      default: begin
        if (take) begin
          next_pc       = 11'(pc + PC_STEP);
          next_reg_addr = i_reg_addr;
          case (i_opcode)
            rotate_right_carry_op: begin
              result     = {carry, i_reg_rdata[7:1]};
              next_carry = i_reg_rdata[0];
            end
            nibble_exchange_op: begin
              result = {i_reg_rdata[3:0], i_reg_rdata[7:4]};
            end
            load_immediate_acc_op: begin
              next_acc = i_imm;
            end
            add_immediate_op, subtract_immediate_op: begin
              next_acc         = add_sum[7:0];
              next_carry       = add_sum[8];
              next_digit_carry = add_low[4];
              next_zero        = (add_sum[7:0] == RESET_DATA);
            end
            and_immediate_op: begin
              next_acc  = acc & i_imm;
              next_zero = ((acc & i_imm) == RESET_DATA);
            end
            or_immediate_op: begin
              next_acc  = acc | i_imm;
              next_zero = ((acc | i_imm) == RESET_DATA);
            end
            xor_immediate_op: begin
              next_acc  = acc ^ i_imm;
              next_zero = ((acc ^ i_imm) == RESET_DATA);
            end
            return_with_literal_op: begin
              next_acc   = i_imm;
              next_pc    = stk.top;
              stk.pop    = 1'b1;
              next_state = (CYCLES_BRANCH == 3) ? st_wait_first : st_wait_last;
            end
            call_op: begin
              stk.push   = 1'b1;
              next_pc    = {i_upper_buffer[UPPER_PC_BIT], i_jump_addr};
              next_state = (CYCLES_BRANCH == 3) ? st_wait_first : st_wait_last;
            end
            jump_op: begin
              next_pc    = {i_upper_buffer[UPPER_PC_BIT], i_jump_addr};
              next_state = (CYCLES_BRANCH == 3) ? st_wait_first : st_wait_last;
            end
            add_with_carry_reg_op, add_register_op: begin
              result           = add_sum[7:0];
              next_carry       = add_sum[8];
              next_digit_carry = add_low[4];
              next_zero        = (add_sum[7:0] == RESET_DATA);
            end
            skip_op: begin
              if (i_skip_cond) begin
                // skipped word is not executed, one extra cycle
                next_pc    = 11'(pc + PC_SKIP_STEP);
                next_state = (CYCLES_SKIP == 3) ? st_wait_first : st_wait_last;
              end
            end
            soft_interrupt_op: begin
              stk.push   = 1'b1;
              next_pc    = SWI_VECTOR;
              next_state = (SWI_CYCLES == 3) ? st_wait_first : st_wait_last;
            end
            bit_clear_op: begin
              next_reg_we    = 1'b1;
              next_reg_wdata = i_reg_rdata & ~bit_mask;
            end
            bit_set_op: begin
              next_reg_we    = 1'b1;
              next_reg_wdata = i_reg_rdata | bit_mask;
            end
            default: begin
              next_pc = 11'(pc + PC_STEP);
            end
          endcase
          // rotate, swap and register add operations route by destination bit
          if (i_opcode inside {rotate_right_carry_op, nibble_exchange_op,
                               add_with_carry_reg_op, add_register_op}) begin
            if (i_dest_sel) begin
              next_reg_we    = 1'b1;
              next_reg_wdata = result;
            end else begin
              next_acc = result;
            end
          end
        end
      end
    endcase
    next_busy = (next_state != st_run);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state       <= st_run;
      busy        <= 1'b0;
      pc          <= RESET_PC;
      acc         <= RESET_DATA;
      carry       <= 1'b0;
      digit_carry <= 1'b0;
      zero        <= 1'b0;
      reg_we      <= 1'b0;
      reg_addr    <= 6'h00;
      reg_wdata   <= RESET_DATA;
    end else begin
      state       <= next_state;
      busy        <= next_busy;
      pc          <= next_pc;
      acc         <= next_acc;
      carry       <= next_carry;
      digit_carry <= next_digit_carry;
      zero        <= next_zero;
      reg_we      <= next_reg_we;
      reg_addr    <= next_reg_addr;
      reg_wdata   <= next_reg_wdata;
    end
  end

  assign o_busy        = busy;
  assign o_pc          = pc;
  assign o_acc         = acc;
  assign o_carry       = carry;
  assign o_digit_carry = digit_carry;
  assign o_zero        = zero;
  assign o_reg_we      = reg_we;
  assign o_reg_addr    = reg_addr;
  assign o_reg_wdata   = reg_wdata;

  // helper values for checks
  logic [7:0] chk_add_imm;
  logic [8:0] chk_sub_imm;
  assign chk_add_imm = 8'(acc + i_imm);
  assign chk_sub_imm = {1'b0, i_imm} + {1'b0, ~acc} + 9'h001;

  a_rotate_right: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    take && i_opcode == rotate_right_carry_op && !i_dest_sel |=>
      o_acc == {$past(carry), $past(i_reg_rdata[7:1])} && o_carry == $past(i_reg_rdata[0]))
    else $error("rotate right result wrong");

  a_swap_flags: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    take && i_opcode == nibble_exchange_op && i_dest_sel |=>
      $stable(o_carry) && $stable(o_zero) && $stable(o_digit_carry) && o_reg_we &&
      o_reg_wdata == {$past(i_reg_rdata[3:0]), $past(i_reg_rdata[7:4])})
    else $error("nibble swap wrong or flags moved");

  a_load_imm: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    take && i_opcode == load_immediate_acc_op |=>
      o_acc == $past(i_imm) && $stable(o_zero) && $stable(o_carry) && !o_busy)
    else $error("load immediate wrong");

  a_add_imm: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    take && i_opcode == add_immediate_op |=>
      o_acc == $past(chk_add_imm) && o_zero == (o_acc == 8'h00))
    else $error("add immediate wrong");

  a_sub_borrow: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    take && i_opcode == subtract_immediate_op |=>
      o_acc == $past(chk_sub_imm[7:0]) && o_carry == $past(i_imm >= acc))
    else $error("subtract immediate or borrow wrong");

  a_logic_zero: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    take && i_opcode inside {and_immediate_op, or_immediate_op, xor_immediate_op} |=>
      $stable(o_carry) && $stable(o_digit_carry) && o_zero == (o_acc == 8'h00))
    else $error("immediate logic flags wrong");

  a_jump_target: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    take && (i_opcode == jump_op || i_opcode == call_op) |=>
      o_pc == {$past(i_upper_buffer[2]), $past(i_jump_addr)} && o_busy ##1 !o_busy)
    else $error("branch target or length wrong");

  a_call_return: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    take && i_opcode == call_op ##2 take && i_opcode == return_with_literal_op |=>
      o_pc == 11'($past(pc, 3) + 11'h001) && o_busy)
    else $error("call return address wrong");

  a_skip_cycles: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    take && i_opcode == skip_op |=> o_busy == $past(i_skip_cond))
    else $error("skip cycle count wrong");

  a_swi_cycles: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    take && i_opcode == soft_interrupt_op |=>
      o_pc == 11'h002 && o_busy ##1 (o_busy == LONG_SWI) ##1 (!LONG_SWI || !o_busy))
    else $error("software interrupt cycle count wrong");

  a_dest_route: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    take && i_opcode == add_register_op |=>
      o_reg_we == $past(i_dest_sel) && o_reg_addr == $past(i_reg_addr))
    else $error("destination routing wrong");
endmodule
`default_nettype wire

// *** verification/reg_file_model.sv ***
// behavioural register file facing the execution unit
// assumes reads are combinational from the address and writes land on the clock edge
`timescale 1ns/100ps
`default_nettype none
module reg_file_model (
  // clock
  input  wire logic       i_clk,
  // read side
  input  wire logic [5:0] i_raddr,
  output logic      [7:0] o_rdata,
  // write side
  input  wire logic       i_we,
  input  wire logic [5:0] i_waddr,
  input  wire logic [7:0] i_wdata
);
  logic [7:0] mem [64];

  // known start contents, mirrored by the bench
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'h81 ^ 8'(i);
    end
  end

  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_raddr];
endmodule
`default_nettype wire

// *** verification/immediate_branch_alu_exec_bench.sv ***
// self-checking bench for the execution unit
// assumes a register file model on the read/write ports; a second unit
// built for the short software interrupt runs in step with the first
`timescale 1ns/100ps
`default_nettype none
module immediate_branch_alu_exec_bench;
  import exec_pkg::*;
  logic        clk, rst_n, vld, dsel, skc, we, busy, c, dc, z, busy_short;
  op_t         op;
  logic [7:0]  imm, rd, ub, acc, wd;
  logic [9:0]  ja;
  logic [5:0]  ra, wa;
  logic [2:0]  bi;
  logic [10:0] pc, pc_e, ret_e, pc_short;
  int          num_errors = 0;
  int          check_count = 0;
  int          cyc = 0;

  immediate_branch_alu_exec immediate_branch_alu_exec_inst (
    .i_clk(clk), .i_reset_n(rst_n), .i_instr_valid(vld), .i_opcode(op),
    .i_imm(imm), .i_jump_addr(ja), .i_reg_addr(ra), .i_bit_index(bi),
    .i_dest_sel(dsel), .i_skip_cond(skc), .i_reg_rdata(rd),
    .i_upper_buffer(ub), .o_busy(busy), .o_pc(pc), .o_acc(acc),
    .o_carry(c), .o_digit_carry(dc), .o_zero(z), .o_reg_we(we),
    .o_reg_addr(wa), .o_reg_wdata(wd));

  // short interrupt variant, same stimulus, only sequencing observed
  immediate_branch_alu_exec #(
    .LONG_SWI(1'b0)
  ) immediate_branch_alu_exec_short_inst (
    .i_clk(clk), .i_reset_n(rst_n), .i_instr_valid(vld), .i_opcode(op),
    .i_imm(imm), .i_jump_addr(ja), .i_reg_addr(ra), .i_bit_index(bi),
    .i_dest_sel(dsel), .i_skip_cond(skc), .i_reg_rdata(rd),
    .i_upper_buffer(ub), .o_busy(busy_short), .o_pc(pc_short), .o_acc(),
    .o_carry(), .o_digit_carry(), .o_zero(), .o_reg_we(),
    .o_reg_addr(), .o_reg_wdata());

  reg_file_model reg_file_model_inst (
    .i_clk(clk), .i_raddr(ra), .o_rdata(rd), .i_we(we), .i_waddr(wa),
    .i_wdata(wd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected flags as {carry, digit carry, zero}
  task automatic flg(input logic [2:0] e);
    check(11'(c), 11'(e[2]));
    check(11'(dc), 11'(e[1]));
    check(11'(z), 11'(e[0]));
  endtask

  // present one instruction, return once its first result is visible
  task automatic issue(input op_t o, input logic [7:0] i);
    op = o;
    imm = i;
    vld = 1'b1;
    @(posedge clk);
    #1;
    pc_e = pc_e + 11'h001;
  endtask

  // drop valid, count the cycles the op occupies, then one idle edge
  task automatic wait_idle(input int exp_n);
    int n;
    n = 1;
    vld = 1'b0;
    while (busy === 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(11'(n), 11'(exp_n));
    @(posedge clk);
    #1;
  endtask

  task automatic t_imm();
    issue(load_immediate_acc_op, 8'hf8);
    check(11'(acc), 11'h0f8);
    flg(3'b000);
    issue(add_immediate_op, 8'h08);
    check(11'(acc), 11'h000);
    flg(3'b111);
    issue(load_immediate_acc_op, 8'h10);
    flg(3'b111);
    issue(subtract_immediate_op, 8'h05);
    check(11'(acc), 11'h0f5);
    flg(3'b010);
    issue(and_immediate_op, 8'h3c);
    check(11'(acc), 11'h034);
    issue(or_immediate_op, 8'h03);
    check(11'(acc), 11'h037);
    flg(3'b010);
    issue(xor_immediate_op, 8'h37);
    check(11'(acc), 11'h000);
    flg(3'b011);
    issue(subtract_immediate_op, 8'h05);
    check(11'(acc), 11'h005);
    flg(3'b110);
    check(pc, pc_e);
  endtask

  task automatic t_reg();
    issue(load_immediate_acc_op, 8'hff);
    issue(add_immediate_op, 8'h01);
    flg(3'b111);
    ra = 6'h01;
    issue(rotate_right_carry_op, 8'h00);
    check(11'(acc), 11'h0c0);
    flg(3'b011);
    check(11'(we), 11'h0);
    ra = 6'h3f;
    dsel = 1'b1;
    issue(nibble_exchange_op, 8'h00);
    check(11'(we), 11'h1);
    check(11'(wa), 11'h3f);
    check(11'(wd), 11'h0eb);
    flg(3'b011);
    check(11'(acc), 11'h0c0);
    wait_idle(1);
    dsel = 1'b0;
    issue(add_register_op, 8'h00);
    check(11'(acc), 11'h0ab);
    flg(3'b100);
    ra = 6'h05;
    dsel = 1'b1;
    issue(add_with_carry_reg_op, 8'h00);
    check(11'(wd), 11'h030);
    check(11'(wa), 11'h05);
    check(11'(acc), 11'h0ab);
    flg(3'b110);
    ra = 6'h00;
    bi = 3'h1;
    issue(bit_set_op, 8'h00);
    check(11'(wd), 11'h083);
    ra = 6'h02;
    bi = 3'h7;
    issue(bit_clear_op, 8'h00);
    check(11'(wd), 11'h003);
    check(11'(we), 11'h1);
    check(pc, pc_e);
    wait_idle(1);
  endtask

  task automatic t_branch();
    ub = 8'h04;
    ja = 10'h155;
    issue(call_op, 8'h00);
    check(pc, 11'h555);
    ret_e = pc_e;
    wait_idle(2);
    ub = 8'hfb;
    ja = 10'h3aa;
    issue(jump_op, 8'h00);
    check(pc, 11'h3aa);
    wait_idle(2);
    issue(return_with_literal_op, 8'h5a);
    check(11'(acc), 11'h05a);
    check(pc, ret_e);
    flg(3'b110);
    wait_idle(2);
    pc_e = ret_e;
    ub = 8'hfb;
    ja = 10'h2c3;
    issue(call_op, 8'h00);
    ret_e = pc_e;
    // fetch holds the return while busy; it is taken once the call ends
    op = return_with_literal_op;
    imm = 8'h3c;
    @(posedge clk);
    #1;
    check(pc, 11'h2c3);
    check(11'(acc), 11'h05a);
    @(posedge clk);
    #1;
    check(pc, ret_e);
    check(11'(acc), 11'h03c);
    wait_idle(2);
  endtask

  task automatic t_skip_swi();
    skc = 1'b0;
    issue(skip_op, 8'h00);
    check(pc, pc_e);
    wait_idle(1);
    skc = 1'b1;
    issue(skip_op, 8'h00);
    pc_e = pc_e + 11'h001;
    check(pc, pc_e);
    wait_idle(2);
    issue(soft_interrupt_op, 8'h00);
    check(pc, 11'h002);
    check(pc_short, 11'h002);
    ret_e = pc_e;
    vld = 1'b0;
    @(posedge clk);
    #1;
    check(11'(busy), 11'h1);
    check(11'(busy_short), 11'h0);
    wait_idle(2);
    issue(return_with_literal_op, 8'h00);
    check(pc, ret_e);
    wait_idle(2);
  endtask

  initial begin
    rst_n = 1'b0;
    vld = 1'b0;
    op = no_op;
    imm = 8'h00;
    ja = 10'h000;
    ra = 6'h00;
    bi = 3'h0;
    dsel = 1'b0;
    skc = 1'b0;
    ub = 8'h00;
    pc_e = 11'h000;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check(pc, 11'h000);
    check(11'(acc), 11'h000);
    t_imm();
    t_reg();
    t_branch();
    t_skip_swi();
    test_done();
  end
endmodule
`default_nettype wire
